/* File: saop_pkg.sv */
// Shared constants, register map and word placement decode for the stereo converter serial port.
package saop_pkg;

    // ****************************************************************
    // Frame geometry
    // ****************************************************************
    localparam int WORD_W = 16;
    localparam int FRAME_TICKS = 128;
    localparam int SCLK_PER_FRAME = 64;
    localparam int SETTLE_WORDS = 68;
    localparam logic [6:0] SETTLE_CNT = 7'h44;
    localparam logic [5:0] WORD_LAST = 6'h0F;
    localparam logic [5:0] RJ_START = 6'h10;
    localparam logic [5:0] LJ_START_EARLY = 6'h01;
    localparam logic [5:0] LJ_START_COINC = 6'h00;

    // ****************************************************************
    // Clock divider select codes
    // ****************************************************************
    localparam logic [1:0] DIV_OFF = 2'h0;
    localparam logic [1:0] DIV_BY1 = 2'h1;
    localparam logic [1:0] DIV_BY2 = 2'h2;
    localparam logic [1:0] DIV_BY3 = 2'h3;

    // ****************************************************************
    // Mode pin vector positions
    // ****************************************************************
    localparam int MP_DIV_LO = 0;
    localparam int MP_DIV_HI = 1;
    localparam int MP_FILTER = 2;
    localparam int MP_SYNCFMT = 3;
    localparam int MP_SLAVE = 4;
    localparam int MP_JUSTIFY = 5;
    localparam int MP_IDLE = 6;
    localparam int MP_W = 7;

    // ****************************************************************
    // Host register map
    // ****************************************************************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_DATA = 8'h08;
    localparam int CTRL_EN = 0;
    localparam int CTRL_MASTER = 1;
    localparam int CTRL_SYNCFMT = 2;
    localparam int CTRL_JUSTIFY = 3;
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam int HOST_HALF_SCLK = 16;

    // Offset of a slot inside the word; values of 16 and above mean outside the word.
    function automatic logic [5:0] wordOffset(input logic [4:0] pos, input logic just, input logic fmt);
        logic [5:0] start;
        start = just ? RJ_START : (fmt ? LJ_START_COINC : LJ_START_EARLY);
        wordOffset = {1'b0, pos} - start;
    endfunction : wordOffset

endpackage : saop_pkg

/* File: saop_if.sv */
// Serial link between the converter port and the host receiver, with pin resolution.
`timescale 1ns/1ns
interface saop_if;
    logic devSync;
    logic devSyncOe;
    logic devSclk;
    logic devSclkOe;
    logic devSdo;
    logic devSdoOe;
    logic hostSync;
    logic hostSyncOe;
    logic hostSclk;
    logic hostSclkOe;
    logic syncLine;
    logic sclkLine;
    logic sdoLine;

    // Undriven lines settle low.
    assign syncLine = devSyncOe ? devSync : (hostSyncOe ? hostSync : 1'b0);
    assign sclkLine = devSclkOe ? devSclk : (hostSclkOe ? hostSclk : 1'b0);
    assign sdoLine = devSdoOe ? devSdo : 1'b0;

    modport dev (
        output devSync, devSyncOe, devSclk, devSclkOe, devSdo, devSdoOe,
        input syncLine, sclkLine
    );
    modport host (
        output hostSync, hostSyncOe, hostSclk, hostSclkOe,
        input syncLine, sclkLine, sdoLine
    );
endinterface : saop_if

/* File: saop_device.sv */
// Converter end: mode pins, sample clock divider and serial output transmitter.
//
// Notes on behaviour
// - Divider select: off, divide by one, two, three.
// - Filter select low picks 48 kHz set.
// - Sync format low: sync one clock early.
// - Sync format high: sync with first bit.
// - Slave select low: drive sync and clock.
// - Slave: reclock sync and clock by sample clock.
// - Justify select: left when low, right high.
// - Idle data pin floats or drives low.
// - Most significant bit first, left before right.
// - Frame is 128 sample ticks, 64 clocks.
// - Master pin changes launched by sample tick.
// - Data timed by sample clock, slave may skew.
// - First 68 words after start are indeterminate.
// - Shared line: both slave, float idle, opposite justify.
// - Shared line: use divide by one.
// - Never share with a master device.
// - Slave start then master keeps sync phase.
// - Both words sampled at the same instant.
// - Network host: four slots of 16 bits.
// - Continuous host: start with sync, then drop.
// - Left word while sync high, right while low.
// - Data changes on serial clock rising edge.
// - Sync rise realigns transmitter and frame counter.
`timescale 1ns/1ns
module saop_device #(
    parameter int WORD_W = saop_pkg::WORD_W
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Mode pins
    input wire logic clkDivSelLo,
    input wire logic clkDivSelHi,
    input wire logic filterSetSel,
    input wire logic syncFormatSel,
    input wire logic slaveSel,
    input wire logic justifySel,
    input wire logic idleDriveSel,
    // Sample source
    input wire logic [WORD_W-1:0] leftSample,
    input wire logic [WORD_W-1:0] rightSample,
    output logic sampleTake,
    // Status
    output logic powerDown,
    output logic coefSet44k,
    output logic outputSettled,
    // Serial link
    saop_if.dev link
);

    // ****************************************************************
    // Mode pin synchroniser
    // ****************************************************************
    logic [saop_pkg::MP_W-1:0] modeMeta_r;
    logic [saop_pkg::MP_W-1:0] mode_r;
    logic [saop_pkg::MP_W-1:0] modePins;

    assign modePins = {idleDriveSel, justifySel, slaveSel, syncFormatSel, filterSetSel, clkDivSelHi, clkDivSelLo};

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            modeMeta_r <= '0;
            mode_r <= '0;
        end else begin
            modeMeta_r <= modePins;
            mode_r <= modeMeta_r;
        end
    end

    logic [1:0] divSel;
    logic slaveMode;
    logic justify;
    logic syncFmt;
    logic idleDrive;

    assign divSel = {mode_r[saop_pkg::MP_DIV_HI], mode_r[saop_pkg::MP_DIV_LO]};
    assign slaveMode = mode_r[saop_pkg::MP_SLAVE];
    assign justify = mode_r[saop_pkg::MP_JUSTIFY];
    assign syncFmt = mode_r[saop_pkg::MP_SYNCFMT];
    assign idleDrive = mode_r[saop_pkg::MP_IDLE];
    assign powerDown = (divSel == saop_pkg::DIV_OFF);
    assign coefSet44k = mode_r[saop_pkg::MP_FILTER];

    // ****************************************************************
    // Internal sample clock divider
    // ****************************************************************
    logic [1:0] divCnt_r;
    logic [1:0] divMax;
    logic tick;

    assign divMax = divSel - saop_pkg::DIV_BY1;
    assign tick = !powerDown && (divCnt_r == 2'h0);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            divCnt_r <= 2'h0;
        end else if (powerDown || divCnt_r == divMax) begin
            divCnt_r <= 2'h0;
        end else begin
            divCnt_r <= divCnt_r + 2'h1;
        end
    end

    // ****************************************************************
    // Slave input reclocking
    // ****************************************************************
    logic syncMeta_r;
    logic syncSyn_r;
    logic sclkMeta_r;
    logic sclkSyn_r;
    logic syncRc_r;
    logic sclkRc_r;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            syncMeta_r <= 1'b0;
            syncSyn_r <= 1'b0;
            sclkMeta_r <= 1'b0;
            sclkSyn_r <= 1'b0;
            syncRc_r <= 1'b0;
            sclkRc_r <= 1'b0;
        end else begin
            syncMeta_r <= link.syncLine;
            syncSyn_r <= syncMeta_r;
            sclkMeta_r <= link.sclkLine;
            sclkSyn_r <= sclkMeta_r;
            if (tick) begin
                syncRc_r <= syncSyn_r;
                sclkRc_r <= sclkSyn_r;
            end
        end
    end

    // ****************************************************************
    // Master frame generator and serial clock events
    // ****************************************************************
    logic [6:0] frameCnt_r;
    logic [6:0] frameNxt;
    logic [5:0] slotCnt_r;
    logic [5:0] slotNxt;
    logic syncPrev_r;
    logic sclkRise;
    logic syncNow;
    logic syncRise;

    assign frameNxt = frameCnt_r + 7'h01;
    assign sclkRise = slaveMode ? (tick && sclkSyn_r && !sclkRc_r) : (tick && !frameCnt_r[0]);
    assign syncNow = slaveMode ? syncSyn_r : !frameNxt[6];
    assign syncRise = syncNow && !syncPrev_r;
    assign slotNxt = syncRise ? 6'h00 : slotCnt_r + 6'h01;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            frameCnt_r <= 7'h00;
            slotCnt_r <= 6'h3F;
            syncPrev_r <= 1'b1;
        end else begin
            if (slaveMode && sclkRise) begin
                frameCnt_r <= {slotNxt, 1'b1};
            end else if (!slaveMode && tick) begin
                frameCnt_r <= frameNxt;
            end
            if (sclkRise) begin
                slotCnt_r <= slotNxt;
                syncPrev_r <= syncNow;
            end
        end
    end

    // Master pins follow the frame counter, which only moves on a tick.
    assign link.devSclk = frameCnt_r[0];
    assign link.devSync = !frameCnt_r[6];
    assign link.devSclkOe = !slaveMode && !powerDown;
    assign link.devSyncOe = !slaveMode && !powerDown;

    // ****************************************************************
    // Word latch and data shifter
    // ****************************************************************
    logic [WORD_W-1:0] leftWord_r;
    logic [WORD_W-1:0] rightWord_r;
    logic [WORD_W-1:0] curLeft;
    logic [5:0] offset;
    logic active;
    logic curBit;
    logic sdo_r;
    logic sdoOe_r;
    logic [6:0] wordCnt_r;
    logic wordDone;

    assign curLeft = syncRise ? leftSample : leftWord_r;
    assign offset = saop_pkg::wordOffset(slotNxt[4:0], justify, syncFmt);
    assign active = (offset <= saop_pkg::WORD_LAST);
    assign curBit = slotNxt[5] ? rightWord_r[~offset[3:0]] : curLeft[~offset[3:0]];
    assign wordDone = sclkRise && active && (offset == saop_pkg::WORD_LAST);
    assign sampleTake = sclkRise && syncRise;
    assign outputSettled = (wordCnt_r == saop_pkg::SETTLE_CNT);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            leftWord_r <= '0;
            rightWord_r <= '0;
        end else if (sampleTake) begin
            leftWord_r <= leftSample;
            rightWord_r <= rightSample;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sdo_r <= 1'b0;
            sdoOe_r <= 1'b0;
        end else if (powerDown) begin
            sdo_r <= 1'b0;
            sdoOe_r <= 1'b0;
        end else if (sclkRise) begin
            sdo_r <= active && curBit;
            sdoOe_r <= active || idleDrive;
        end
    end

    assign link.devSdo = sdo_r;
    assign link.devSdoOe = sdoOe_r;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wordCnt_r <= 7'h00;
        end else if (powerDown) begin
            wordCnt_r <= 7'h00;
        end else if (wordDone && !outputSettled) begin
            wordCnt_r <= wordCnt_r + 7'h01;
        end
    end

endmodule : saop_device

/* File: saop_host.sv */
// Host end: serial receiver with optional clock and sync generation, controlled over APB.
`timescale 1ns/1ns
module saop_host #(
    parameter int WORD_W = saop_pkg::WORD_W,
    parameter int HALF_SCLK = saop_pkg::HOST_HALF_SCLK
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Received pair
    output logic pairValid,
    // Serial link
    saop_if.host link
);

    // ****************************************************************
    // Control register
    // ****************************************************************
    logic [3:0] ctrl_r;
    logic enable;
    logic hostMaster;
    logic syncFmt;
    logic justify;
    logic apbAccess;
    logic selCtrl;
    logic selStat;
    logic selData;

    assign enable = ctrl_r[saop_pkg::CTRL_EN];
    assign hostMaster = ctrl_r[saop_pkg::CTRL_MASTER];
    assign syncFmt = ctrl_r[saop_pkg::CTRL_SYNCFMT];
    assign justify = ctrl_r[saop_pkg::CTRL_JUSTIFY];
    assign apbAccess = psel && penable;
    assign selCtrl = (paddr == saop_pkg::REG_CTRL);
    assign selStat = (paddr == saop_pkg::REG_STAT);
    assign selData = (paddr == saop_pkg::REG_DATA);
    assign pready = 1'b1;
    assign pslverr = apbAccess && !(selCtrl || selStat || selData);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_r <= saop_pkg::CTRL_RST;
        end else if (apbAccess && pwrite && selCtrl) begin
            ctrl_r <= pwdata[3:0];
        end
    end

    // ****************************************************************
    // Clock and sync generation when the host is master
    // ****************************************************************
    logic [7:0] halfCnt_r;
    logic genSclk_r;
    logic [5:0] genSlot_r;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            halfCnt_r <= 8'h00;
            genSclk_r <= 1'b0;
            genSlot_r <= 6'h3F;
        end else if (!(enable && hostMaster)) begin
            halfCnt_r <= 8'h00;
            genSclk_r <= 1'b0;
            genSlot_r <= 6'h3F;
        end else if (halfCnt_r == 8'(HALF_SCLK - 1)) begin
            halfCnt_r <= 8'h00;
            genSclk_r <= !genSclk_r;
            if (!genSclk_r) begin
                genSlot_r <= genSlot_r + 6'h01;
            end
        end else begin
            halfCnt_r <= halfCnt_r + 8'h01;
        end
    end

    assign link.hostSclk = genSclk_r;
    assign link.hostSync = !genSlot_r[5];
    assign link.hostSclkOe = enable && hostMaster;
    assign link.hostSyncOe = enable && hostMaster;

    // ****************************************************************
    // Line synchronisers and receive slot tracking
    // ****************************************************************
    logic [2:0] lineMeta_r;
    logic [2:0] lineSyn_r;
    logic sclkPrev_r;
    logic syncPrev_r;
    logic [5:0] slot_r;
    logic sclkRise;
    logic sclkFall;
    logic syncRise;

    assign sclkRise = lineSyn_r[1] && !sclkPrev_r;
    assign sclkFall = !lineSyn_r[1] && sclkPrev_r;
    assign syncRise = lineSyn_r[0] && !syncPrev_r;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lineMeta_r <= 3'h0;
            lineSyn_r <= 3'h0;
            sclkPrev_r <= 1'b0;
            syncPrev_r <= 1'b1;
            slot_r <= 6'h3F;
        end else begin
            lineMeta_r <= {link.sdoLine, link.sclkLine, link.syncLine};
            lineSyn_r <= lineMeta_r;
            sclkPrev_r <= lineSyn_r[1];
            if (sclkRise) begin
                syncPrev_r <= lineSyn_r[0];
                slot_r <= syncRise ? 6'h00 : slot_r + 6'h01;
            end
        end
    end

    // ****************************************************************
    // Word capture, settle discard and pair register
    // ****************************************************************
    logic [5:0] offset;
    logic capture;
    logic lastBit;
    logic [WORD_W-1:0] shift_r;
    logic [WORD_W-1:0] shiftNxt;
    logic [WORD_W-1:0] leftHold_r;
    logic [31:0] data_r;
    logic ready_r;
    logic overrun_r;
    logic [6:0] wordCnt_r;
    logic settled;
    logic pairDone;
    logic dataRead;

    assign offset = saop_pkg::wordOffset(slot_r[4:0], justify, syncFmt);
    assign capture = enable && sclkFall && (offset <= saop_pkg::WORD_LAST);
    assign lastBit = capture && (offset == saop_pkg::WORD_LAST);
    assign shiftNxt = {shift_r[WORD_W-2:0], lineSyn_r[2]};
    assign settled = (wordCnt_r == saop_pkg::SETTLE_CNT);
    assign pairDone = lastBit && slot_r[5] && settled;
    assign pairValid = pairDone;
    assign dataRead = apbAccess && !pwrite && selData;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            shift_r <= '0;
            leftHold_r <= '0;
            data_r <= 32'h0000_0000;
            wordCnt_r <= 7'h00;
        end else begin
            if (capture) begin
                shift_r <= shiftNxt;
            end
            if (lastBit && !slot_r[5]) begin
                leftHold_r <= shiftNxt;
            end
            if (pairDone) begin
                data_r <= {leftHold_r, shiftNxt};
            end
            if (!enable) begin
                wordCnt_r <= 7'h00;
            end else if (lastBit && !settled) begin
                wordCnt_r <= wordCnt_r + 7'h01;
            end
        end
    end

    // A new pair wins over the clear from a read in the same cycle.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ready_r <= 1'b0;
            overrun_r <= 1'b0;
        end else begin
            ready_r <= pairDone || (ready_r && !dataRead);
            overrun_r <= (pairDone && ready_r && !dataRead) || (overrun_r && !(apbAccess && !pwrite && selStat));
        end
    end

    assign prdata = selCtrl ? {28'h000_0000, ctrl_r} :
                    selStat ? {22'h00_0000, slot_r, overrun_r, settled, enable, ready_r} :
                    selData ? data_r : 32'h0000_0000;

endmodule : saop_host

/* File: saop_properties.sv */
// Concurrent checks on the serial link between the converter port and the host.
`timescale 1ns/1ns
module saop_properties (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Link signals
    input wire logic devSync,
    input wire logic devSyncOe,
    input wire logic devSclkOe,
    input wire logic devSdo,
    input wire logic devSdoOe,
    input wire logic hostSyncOe,
    input wire logic hostSclkOe,
    input wire logic sclkLine
);
    logic sclkPrev_r, syncPrev_r, oePrev_r, armed_r;
    logic [6:0] frameCnt_r;
    logic [4:0] wordCnt_r;
    logic [5:0] since_r;
    wire sclkRise = sclkLine & ~sclkPrev_r;
    wire syncRise = devSync & ~syncPrev_r;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // ****
    // Slot counters.
    // ****
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            {sclkPrev_r, syncPrev_r, oePrev_r, armed_r} <= 4'h0;
            frameCnt_r <= 7'h00;
            wordCnt_r <= 5'h00;
            since_r <= 6'h00;
        end else begin
            {sclkPrev_r, syncPrev_r, oePrev_r} <= {sclkLine, devSync, devSdoOe};
            armed_r <= devSyncOe & (armed_r | syncRise);
            frameCnt_r <= syncRise ? 7'h00 : frameCnt_r + {6'h00, sclkRise};
            wordCnt_r <= (devSdoOe & ~oePrev_r) ? 5'h01 : wordCnt_r + {4'h0, devSdoOe & sclkRise};
            since_r <= sclkRise ? 6'h00 : since_r + {5'h00, since_r != 6'h3F};
        end
    end

    // ****
    // Assertions.
    // ****
    oe_pair_a: assert property (devSyncOe == devSclkOe)
        else $error("sync and clock enables differ");
    no_contention_a: assert property (!(devSyncOe && hostSyncOe) && !(devSclkOe && hostSclkOe))
        else $error("both ends drive the link");
    sync_launch_a: assert property (devSyncOe && $past(devSyncOe) && $changed(devSync) |-> $fell(sclkLine))
        else $error("sync moved off a clock fall");
    sdo_launch_a: assert property (devSclkOe && $past(devSclkOe) && devSdoOe && $changed(devSdo) |-> sclkRise)
        else $error("data moved off a clock rise");
    frame_len_a: assert property (devSyncOe && syncRise && armed_r |-> frameCnt_r == 7'h40)
        else $error("frame length wrong");
    left_half_a: assert property (devSyncOe && armed_r && $fell(devSync) |-> frameCnt_r == 7'h20)
        else $error("sync high length wrong");
    word_len_a: assert property (devSclkOe && oePrev_r && !devSdoOe |-> wordCnt_r == 5'h10)
        else $error("word length wrong");
    slave_skew_a: assert property (!devSclkOe && devSdoOe && $past(devSdoOe) && $changed(devSdo) |-> since_r <= 6'h0A)
        else $error("slave data late");

    frame_c: cover property (syncRise && armed_r);
    word_c: cover property (devSclkOe && oePrev_r && !devSdoOe);
    slave_c: cover property (!devSclkOe && devSdoOe && $changed(devSdo));
endmodule : saop_properties

/* File: tb_stereo_adc_serial_output_port.sv */
// Self-checking bench joining the converter port and its host receiver.
`timescale 1ns/1ns
module tb_stereo_adc_serial_output_port;
    typedef struct packed {
        logic [1:0] div;
        logic filt, fmt, slv, just, idle;
        logic [15:0] lw, rw;
    } saop_row_t;
    logic ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic clkDivSelLo = 1'b0, clkDivSelHi = 1'b0, filterSetSel = 1'b0, syncFormatSel = 1'b0;
    logic slaveSel = 1'b0, justifySel = 1'b0, idleDriveSel = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [15:0] leftSample = 16'h0000, rightSample = 16'h0000;
    logic pready, pslverr, pairValid, powerDown, coefSet44k, outputSettled, err, sampleTake;
    logic [35:0] snap;
    int n_errors = 0, checks_done = 0, n, nTake;
    saop_row_t rows [5];
    saop_if link ();

    saop_device i_saop_device (.ref_clk, .rst, .clkDivSelLo, .clkDivSelHi, .filterSetSel, .syncFormatSel,
        .slaveSel, .justifySel, .idleDriveSel, .leftSample, .rightSample, .sampleTake, .powerDown,
        .coefSet44k, .outputSettled, .link(link));
    saop_host #(.HALF_SCLK(8)) i_saop_host (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .pairValid, .link(link));
    saop_properties i_saop_properties (.ref_clk, .rst, .devSync(link.devSync), .devSyncOe(link.devSyncOe),
        .devSclkOe(link.devSclkOe), .devSdo(link.devSdo), .devSdoOe(link.devSdoOe),
        .hostSyncOe(link.hostSyncOe), .hostSclkOe(link.hostSclkOe), .sclkLine(link.sclkLine));

    always #25 ref_clk = ~ref_clk;
    // Outputs only move at rising edges, so this copy is what the next rising edge samples.
    always @(negedge ref_clk) snap = {sampleTake, pairValid, pready, pslverr, prdata};

    // ****
    // Shared tasks.
    // ****
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic summarize;
        $display("errors %0d, checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            k++;
        end while (snap[33] !== 1'b1 && k < 20);
        rd = snap[31:0];
        err = snap[32];
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin
            n_errors++;
            summarize();
        end
    endtask : apb

    task automatic waitPair;
        n = 0;
        nTake = 0;
        do begin
            @(posedge ref_clk);
            n++;
            nTake += snap[35];
        end while (snap[34] !== 1'b1 && n < 40000);
        if (n >= 40000) begin
            n_errors++;
            summarize();
        end
    endtask : waitPair

    // ****
    // Main sequence.
    // ****
    initial begin
        rows[0] = '{2'h1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h8001, 16'h7FFE};
        rows[1] = '{2'h2, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 16'hA5C3, 16'h3C5A};
        rows[2] = '{2'h3, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 16'hFFFF, 16'h0000};
        rows[3] = '{2'h1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 16'h1234, 16'hFEDC};
        rows[4] = '{2'h1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 16'h0F0F, 16'hC001};
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        apb(1'b0, saop_pkg::REG_CTRL, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        foreach (rows[i]) begin
            clkDivSelLo <= 1'b0;
            clkDivSelHi <= 1'b0;
            apb(1'b1, saop_pkg::REG_CTRL, 32'h0000_0000);
            repeat (4) @(posedge ref_clk);
            chk({powerDown, link.devSdoOe, link.devSyncOe}, 3'h4);
            filterSetSel <= rows[i].filt;
            syncFormatSel <= rows[i].fmt;
            slaveSel <= rows[i].slv;
            justifySel <= rows[i].just;
            idleDriveSel <= rows[i].idle;
            leftSample <= rows[i].lw;
            rightSample <= rows[i].rw;
            apb(1'b1, saop_pkg::REG_CTRL, {28'h000_0000, rows[i].just, rows[i].fmt, rows[i].slv, 1'b1});
            clkDivSelLo <= rows[i].div[0];
            clkDivSelHi <= rows[i].div[1];
            repeat (4) @(posedge ref_clk);
            chk({powerDown, coefSet44k, link.devSyncOe}, {1'b0, rows[i].filt, !rows[i].slv});
            waitPair();
            chk(32'(n >= 33 * (rows[i].slv ? 1024 : 128 * rows[i].div)), 32'h0000_0001);
            chk(outputSettled, 1'b1);
            chk(32'(nTake >= 33), 32'h0000_0001);
            apb(1'b0, saop_pkg::REG_STAT, 32'h0000_0000);
            chk(rd[2:0], 3'h7);
            apb(1'b0, saop_pkg::REG_DATA, 32'h0000_0000);
            chk(rd, {rows[i].lw, rows[i].rw});
            apb(1'b0, saop_pkg::REG_STAT, 32'h0000_0000);
            chk(rd[0], 1'b0);
        end
        apb(1'b1, 8'hFC, 32'hFFFF_FFFF);
        chk(err, 1'b1);
        apb(1'b0, 8'hFC, 32'h0000_0000);
        chk({err, rd[15:0]}, {1'b1, 16'h0000});
        apb(1'b0, saop_pkg::REG_CTRL, 32'h0000_0000);
        chk(rd, 32'h0000_0007);
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        apb(1'b0, saop_pkg::REG_CTRL, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        apb(1'b0, saop_pkg::REG_STAT, 32'h0000_0000);
        chk({outputSettled, rd[3:0]}, 5'h00);
        summarize();
    end
endmodule : tb_stereo_adc_serial_output_port
